// ### inc/drive_flags_pkg.sv
// constants of the drive flags and analog input object block
// Summary of operation
// - legacy flag 0 in switched-on state: pwm fixed at half duty, no torque
// - legacy flag 1 in switched-on state: controller drives pwm, holding torque
// - field override 0: use built-in default rotating field direction
// - field override 1: force non-inverted (positive) rotating field
// - field override -1: force inverted (negative) rotating field
// - keep-gains 0: auto setup detects motor type, loads matching preset gains
// - keep-gains 1: auto setup uses stored gains and leaves them unchanged
// - two signed 16-bit read-only analog readings in digits, reset to zero
// - voltage mode: x digits equals x times 10 V over 1024
// - current mode: x digits equals x times 20 mA over 1024
// - control word bit 0 is channel one, bit 1 channel two; 1 selects current
// - new field override takes effect only after controller restart, then auto setup
package drive_flags_pkg;
  // ****************************************
  // object indices and subindices
  // ****************************************
  localparam logic [15:0] idx_drive_flags = 16'h3212;
  localparam logic [15:0] idx_analog_inputs = 16'h3220;
  localparam logic [15:0] idx_analog_control = 16'h3221;
  localparam logic [7:0] sub_count = 8'h00;
  localparam logic [7:0] sub_legacy_power = 8'h01;
  localparam logic [7:0] sub_field_override = 8'h02;
  localparam logic [7:0] sub_keep_gains = 8'h03;
  localparam logic [7:0] sub_reading_one = 8'h01;
  localparam logic [7:0] sub_reading_two = 8'h02;
  // ****************************************
  // reset and fixed values
  // ****************************************
  localparam logic [7:0] drive_flags_count_value = 8'h03;
  localparam logic [7:0] analog_count_value = 8'h02;
  localparam logic [7:0] flag_reset = 8'h00;
  localparam logic [15:0] reading_reset = 16'h0000;
  localparam logic [1:0] measure_sel_reset = 2'h0;
  localparam logic [7:0] flag_on = 8'h01;
  localparam logic [7:0] field_force_normal = 8'h01;
  localparam logic [7:0] field_force_inverted = 8'hff;
  // ****************************************
  // control word fields
  // ****************************************
  localparam int chan_one_current_sel = 0;
  localparam int chan_two_current_sel = 1;
  // ****************************************
  // scaling: full scale per 1024 digits
  // ****************************************
  localparam logic [4:0] volt_full_scale = 5'h0a;
  localparam logic [4:0] milliamp_full_scale = 5'h14;
  localparam int digits_per_full_scale = 1024;
endpackage

// ### rtl/drive_flags_analog_inputs.sv
// object dictionary entries for motor drive flags and analog inputs
module drive_flags_analog_inputs #(
  parameter int pwm_w = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // object access port
  input wire logic od_write,
  input wire logic [15:0] od_index,
  input wire logic [7:0] od_subindex,
  input wire logic [31:0] od_wdata,
  output logic [31:0] od_rdata,
  output logic od_error,
  // power stage
  input wire logic switched_on,
  input wire logic [pwm_w-1:0] ctrl_pwm_duty,
  output logic [pwm_w-1:0] pwm_duty,
  output logic holding_torque,
  // rotating field
  input wire logic default_field_inverted,
  input wire logic controller_restart,
  output logic field_inverted,
  // auto setup
  input wire logic autosetup_start,
  input wire logic motor_is_bldc,
  output logic load_stepper_preset,
  output logic load_bldc_preset,
  output logic use_stored_gains,
  output logic gains_write_enable,
  // analog inputs
  input wire logic signed [15:0] adc_one,
  input wire logic signed [15:0] adc_two,
  output logic [1:0] measure_current,
  output logic signed [20:0] scaled_one,
  output logic signed [20:0] scaled_two
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] legacy_power;
    logic [7:0] field_override;
    logic [7:0] keep_gains;
    logic [1:0] measure_sel;
    logic [15:0] reading_one;
    logic [15:0] reading_two;
    logic field_inverted;
    logic [31:0] rdata;
    logic err;
    logic [pwm_w-1:0] pwm;
    logic torque;
    logic stepper_load;
    logic bldc_load;
    logic stored_gains;
    logic signed [20:0] scaled_one;
    logic signed [20:0] scaled_two;
  } state_t;

  localparam logic [pwm_w-1:0] half_duty = {1'b1, {(pwm_w-1){1'b0}}};

  if (pwm_w < 2) begin : g_check
    $error("pwm_w must be at least 2");
  end

  state_t s;
  state_t next_s;

  function automatic logic signed [20:0] scale(input logic [15:0] x, input logic cur);
    logic signed [20:0] wide;
    logic signed [20:0] fs;
    wide = 21'(signed'(x));
    fs = cur ? 21'(drive_flags_pkg::milliamp_full_scale) : 21'(drive_flags_pkg::volt_full_scale);
    return 21'(wide * fs);
  endfunction

  always_comb begin
    logic hit_flags;
    logic hit_analog;
    logic hit_ctrl;
    hit_flags = (od_index == drive_flags_pkg::idx_drive_flags);
    hit_analog = (od_index == drive_flags_pkg::idx_analog_inputs);
    hit_ctrl = (od_index == drive_flags_pkg::idx_analog_control);
    next_s = s;
    // ****************************************
    // read path, registered one cycle
    // ****************************************
    next_s.rdata = 32'h0000_0000;
    next_s.err = 1'b0;
    if (hit_flags) begin
      unique case (od_subindex)
        drive_flags_pkg::sub_count: next_s.rdata = {24'h000000, drive_flags_pkg::drive_flags_count_value};
        drive_flags_pkg::sub_legacy_power: next_s.rdata = {{24{s.legacy_power[7]}}, s.legacy_power};
        drive_flags_pkg::sub_field_override: next_s.rdata = {{24{s.field_override[7]}}, s.field_override};
        drive_flags_pkg::sub_keep_gains: next_s.rdata = {{24{s.keep_gains[7]}}, s.keep_gains};
        default: next_s.err = 1'b1;
      endcase
    end else if (hit_analog) begin
      unique case (od_subindex)
        drive_flags_pkg::sub_count: next_s.rdata = {24'h000000, drive_flags_pkg::analog_count_value};
        drive_flags_pkg::sub_reading_one: next_s.rdata = {{16{s.reading_one[15]}}, s.reading_one};
        drive_flags_pkg::sub_reading_two: next_s.rdata = {{16{s.reading_two[15]}}, s.reading_two};
        default: next_s.err = 1'b1;
      endcase
      if (od_write) begin
        next_s.err = 1'b1; // read-only entries
      end
    end else if (hit_ctrl) begin
      next_s.rdata = {30'h0, s.measure_sel};
      next_s.err = (od_subindex != drive_flags_pkg::sub_count);
    end else begin
      next_s.err = 1'b1;
    end
    // ****************************************
    // write path
    // ****************************************
    if (od_write && hit_flags) begin
      unique case (od_subindex)
        drive_flags_pkg::sub_legacy_power: next_s.legacy_power = od_wdata[7:0];
        drive_flags_pkg::sub_field_override: next_s.field_override = od_wdata[7:0];
        drive_flags_pkg::sub_keep_gains: next_s.keep_gains = od_wdata[7:0];
        default: next_s.err = 1'b1;
      endcase
    end
    if (od_write && hit_ctrl && od_subindex == drive_flags_pkg::sub_count) begin
      next_s.measure_sel = od_wdata[1:0]; // upper bits dropped
    end
    // ****************************************
    // power stage
    // ****************************************
    if (switched_on && s.legacy_power == drive_flags_pkg::flag_on) begin
      next_s.pwm = ctrl_pwm_duty;
      next_s.torque = 1'b1;
    end else if (switched_on) begin
      next_s.pwm = half_duty;
      next_s.torque = 1'b0;
    end else begin
      next_s.pwm = ctrl_pwm_duty;
      next_s.torque = 1'b0;
    end
    // ****************************************
    // field direction, sampled at restart only
    // ****************************************
    if (controller_restart) begin
      if (s.field_override == drive_flags_pkg::field_force_normal) begin
        next_s.field_inverted = 1'b0;
      end else if (s.field_override == drive_flags_pkg::field_force_inverted) begin
        next_s.field_inverted = 1'b1;
      end else begin
        next_s.field_inverted = default_field_inverted;
      end
    end
    // ****************************************
    // auto setup gain handling
    // ****************************************
    next_s.stepper_load = 1'b0;
    next_s.bldc_load = 1'b0;
    next_s.stored_gains = 1'b0;
    if (autosetup_start) begin
      if (s.keep_gains == drive_flags_pkg::flag_on) begin
        next_s.stored_gains = 1'b1;
      end else begin
        next_s.bldc_load = motor_is_bldc;
        next_s.stepper_load = !motor_is_bldc;
      end
    end
    // ****************************************
    // analog readings
    // ****************************************
    next_s.reading_one = adc_one;
    next_s.reading_two = adc_two;
    // units of 1/1024 V or 1/1024 mA per digit
    next_s.scaled_one = scale(s.reading_one, s.measure_sel[drive_flags_pkg::chan_one_current_sel]);
    next_s.scaled_two = scale(s.reading_two, s.measure_sel[drive_flags_pkg::chan_two_current_sel]);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.legacy_power <= drive_flags_pkg::flag_reset;
      s.field_override <= drive_flags_pkg::flag_reset;
      s.keep_gains <= drive_flags_pkg::flag_reset;
      s.measure_sel <= drive_flags_pkg::measure_sel_reset;
      s.reading_one <= drive_flags_pkg::reading_reset;
      s.reading_two <= drive_flags_pkg::reading_reset;
      s.pwm <= half_duty;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign od_rdata = s.rdata;
  assign od_error = s.err;
  assign pwm_duty = s.pwm;
  assign holding_torque = s.torque;
  assign field_inverted = s.field_inverted;
  assign load_stepper_preset = s.stepper_load;
  assign load_bldc_preset = s.bldc_load;
  assign use_stored_gains = s.stored_gains;
  // stored gains are never rewritten by an auto setup started while keep-gains is on
  assign gains_write_enable = s.stepper_load | s.bldc_load;
  assign measure_current = s.measure_sel;
  assign scaled_one = s.scaled_one;
  assign scaled_two = s.scaled_two;

  // ****************************************
  // checks
  // ****************************************
  a_half_duty: assert property (@(posedge clock) disable iff (rst)
    switched_on && s.legacy_power != drive_flags_pkg::flag_on |=> pwm_duty == half_duty && !holding_torque)
    else $error("pwm not at half duty");
  a_ctrl_duty: assert property (@(posedge clock) disable iff (rst)
    switched_on && s.legacy_power == drive_flags_pkg::flag_on |=> pwm_duty == $past(ctrl_pwm_duty) && holding_torque)
    else $error("pwm not from controller");
  a_field_default: assert property (@(posedge clock) disable iff (rst)
    controller_restart && s.field_override == 8'h00 |=> field_inverted == $past(default_field_inverted))
    else $error("default field not used");
  a_field_normal: assert property (@(posedge clock) disable iff (rst)
    controller_restart && s.field_override == 8'h01 |=> !field_inverted)
    else $error("field not forced normal");
  a_field_invert: assert property (@(posedge clock) disable iff (rst)
    controller_restart && s.field_override == 8'hff |=> field_inverted)
    else $error("field not forced inverted");
  a_field_hold: assert property (@(posedge clock) disable iff (rst)
    !controller_restart |=> $stable(field_inverted))
    else $error("field changed without restart");
  a_preset_load: assert property (@(posedge clock) disable iff (rst)
    autosetup_start && s.keep_gains == 8'h00 |=> (load_bldc_preset == $past(motor_is_bldc)) && gains_write_enable)
    else $error("preset not loaded");
  a_keep_gains: assert property (@(posedge clock) disable iff (rst)
    autosetup_start && s.keep_gains == 8'h01 |=> use_stored_gains && !gains_write_enable)
    else $error("stored gains touched");
  a_reading_path: assert property (@(posedge clock) disable iff (rst)
    od_index == drive_flags_pkg::idx_analog_inputs && od_subindex == drive_flags_pkg::sub_reading_one
      |=> od_rdata == 32'(signed'($past(s.reading_one))))
    else $error("reading one not returned");
  a_volt_scale: assert property (@(posedge clock) disable iff (rst)
    !s.measure_sel[0] |=> scaled_one == 21'(signed'($past(s.reading_one)) * 10))
    else $error("voltage scale wrong");
  a_amp_scale: assert property (@(posedge clock) disable iff (rst)
    s.measure_sel[1] |=> scaled_two == 21'(signed'($past(s.reading_two)) * 20))
    else $error("current scale wrong");
  a_ctrl_write: assert property (@(posedge clock) disable iff (rst)
    od_write && od_index == 16'h3221 && od_subindex == 8'h00 |=> measure_current == 2'($past(od_wdata)))
    else $error("control word not stored");
  a_ctrl_upper: assert property (@(posedge clock) disable iff (rst)
    od_index == drive_flags_pkg::idx_analog_control |=> od_rdata[31:2] == 30'h0)
    else $error("control upper bits not zero");
endmodule

// ### testbench/test_drive_flags_analog_inputs.sv
// self-checking bench for the drive flags and analog input objects
module test_drive_flags_analog_inputs;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  logic clock = 1'b0, rst = 1'b1, od_write = 1'b0, od_error, switched_on = 1'b0, holding_torque;
  logic [15:0] od_index = 16'h0000, ctrl_pwm_duty = 16'h0000, pwm_duty;
  logic [7:0] od_subindex = 8'h00;
  logic [31:0] od_wdata = 32'h0, od_rdata;
  logic default_field_inverted = 1'b0, controller_restart = 1'b0, field_inverted;
  logic autosetup_start = 1'b0, motor_is_bldc = 1'b0, load_stepper_preset, load_bldc_preset;
  logic use_stored_gains, gains_write_enable;
  logic signed [15:0] adc_one = 16'sh0, adc_two = 16'sh0;
  logic [1:0] measure_current;
  logic signed [20:0] scaled_one, scaled_two;
  int n_errors = 0, comparisons = 0;
  int fl[4] = '{3, 0, 0, 0};
  int meas = 0, a1, a2, v;
  logic exp_field = 1'b0;
  always #5 clock = ~clock;
  drive_flags_analog_inputs drive_flags_analog_inputs_i (.clock(clock), .rst(rst), .od_write(od_write),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata),
    .od_error(od_error), .switched_on(switched_on), .ctrl_pwm_duty(ctrl_pwm_duty), .pwm_duty(pwm_duty),
    .holding_torque(holding_torque), .default_field_inverted(default_field_inverted),
    .controller_restart(controller_restart), .field_inverted(field_inverted),
    .autosetup_start(autosetup_start), .motor_is_bldc(motor_is_bldc),
    .load_stepper_preset(load_stepper_preset), .load_bldc_preset(load_bldc_preset),
    .use_stored_gains(use_stored_gains), .gains_write_enable(gains_write_enable), .adc_one(adc_one),
    .adc_two(adc_two), .measure_current(measure_current), .scaled_one(scaled_one), .scaled_two(scaled_two));
  // ****************************************
  // compare, access and model helpers
  // ****************************************
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  function automatic logic [31:0] flag_rd(input int s);
    logic [7:0] b;
    b = fl[s][7:0];
    return (s == 0) ? 32'h3 : {{24{b[7]}}, b};
  endfunction
  // od_write stays as set until the next access, so groups always end on a read
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd,
                     input logic [31:0] exp, input logic err);
    od_write = w;
    od_index = idx;
    od_subindex = sub;
    od_wdata = wd;
    @(negedge clock);
    chk_bit("od_error", err, od_error);
    if (!err) chk_word("od_rdata", exp, od_rdata);
  endtask
  task automatic wflag(input int s, input int val);
    acc(1'b1, 16'h3212, 8'(s), 32'(val), flag_rd(s), 1'b0);
    fl[s] = val & 32'hff;
    acc(1'b0, 16'h3212, 8'(s), 32'h0, flag_rd(s), 1'b0);
  endtask
  task automatic wmeas(input int val);
    acc(1'b1, 16'h3221, 8'h00, 32'(val), 32'(meas), 1'b0);
    meas = val & 3;
    acc(1'b0, 16'h3221, 8'h00, 32'h0, 32'(meas), 1'b0);
    chk_word("measure_current", 32'(meas), 32'(measure_current));
  endtask
  task automatic test_done;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(67));
    repeat (5) @(negedge clock);
    rst = 1'b0;
    for (int s = 0; s < 4; s++) acc(1'b0, 16'h3212, 8'(s), 32'h0, flag_rd(s), 1'b0);
    acc(1'b0, 16'h3220, 8'h00, 32'h0, 32'h2, 1'b0);
    acc(1'b0, 16'h3220, 8'h01, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 16'h3220, 8'h02, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 16'h3221, 8'h00, 32'h0, 32'h0, 1'b0);
    // read-only, unmapped and count entries refuse writes
    acc(1'b1, 16'h3212, 8'h00, 32'h7, 32'h0, 1'b1);
    acc(1'b1, 16'h3220, 8'h01, 32'h55, 32'h0, 1'b1);
    acc(1'b1, 16'h3213, 8'h00, 32'h1, 32'h0, 1'b1);
    acc(1'b1, 16'h3221, 8'h01, 32'h1, 32'h0, 1'b1);
    acc(1'b0, 16'h3212, 8'h00, 32'h0, 32'h3, 1'b0);
    wmeas(32'hffffffff);
    // random readings in both measuring modes
    for (int i = 0; i < 8; i++) begin
      wmeas(int'($urandom));
      a1 = $signed(16'($urandom));
      a2 = $signed(16'($urandom));
      adc_one = 16'(a1);
      adc_two = 16'(a2);
      repeat (3) @(negedge clock);
      chk_word("scaled_one", 32'(a1 * (meas[0] ? 20 : 10)), 32'(scaled_one));
      chk_word("scaled_two", 32'(a2 * (meas[1] ? 20 : 10)), 32'(scaled_two));
      acc(1'b0, 16'h3220, 8'h01, 32'h0, 32'(a1), 1'b0);
      acc(1'b0, 16'h3220, 8'h02, 32'h0, 32'(a2), 1'b0);
    end
    // power stage in and out of switched-on
    for (int i = 0; i < 6; i++) begin
      wflag(1, (i < 2) ? 0 : (i < 4) ? 1 : 2);
      switched_on = i[0];
      ctrl_pwm_duty = 16'($urandom);
      repeat (2) @(negedge clock);
      v = (switched_on && fl[1] != 1) ? 32'h8000 : 32'(ctrl_pwm_duty);
      chk_word("pwm_duty", 32'(v), 32'(pwm_duty));
      chk_bit("holding_torque", switched_on && fl[1] == 1, holding_torque);
    end
    // field direction changes only across a restart
    for (int i = 0; i < 8; i++) begin
      wflag(2, (i < 2) ? 1 : (i < 4) ? 32'hff : (i < 6) ? 0 : 5);
      default_field_inverted = i[0];
      @(negedge clock);
      chk_bit("field_inverted", exp_field, field_inverted);
      controller_restart = 1'b1;
      @(negedge clock);
      controller_restart = 1'b0;
      exp_field = (fl[2] == 1) ? 1'b0 : (fl[2] == 8'hff) ? 1'b1 : default_field_inverted;
      chk_bit("field_inverted", exp_field, field_inverted);
      autosetup_start = 1'b1;
      @(negedge clock);
      autosetup_start = 1'b0;
    end
    // auto setup with and without kept gains
    for (int i = 0; i < 6; i++) begin
      wflag(3, i / 2);
      motor_is_bldc = i[0];
      autosetup_start = 1'b1;
      @(negedge clock);
      autosetup_start = 1'b0;
      chk_bit("use_stored_gains", fl[3] == 1, use_stored_gains);
      chk_bit("gains_write_enable", fl[3] != 1, gains_write_enable);
      chk_bit("load_bldc_preset", fl[3] != 1 && motor_is_bldc, load_bldc_preset);
      chk_bit("load_stepper_preset", fl[3] != 1 && !motor_is_bldc, load_stepper_preset);
      @(negedge clock);
      chk_bit("use_stored_gains", 1'b0, use_stored_gains);
    end
    // second reset at the end of the run restores the flag and control word reset values
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    fl = '{3, 0, 0, 0};
    meas = 0;
    chk_word("measure_current", 32'h0, 32'(measure_current));
    for (int s = 1; s < 4; s++) acc(1'b0, 16'h3212, 8'(s), 32'h0, flag_rd(s), 1'b0);
    test_done();
  end
endmodule
